// File: shared/rsw_defs.svh
// constants for the reset, sleep and watchdog controller
// assumes inclusion by bare name from shared/
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

`define RSW_ADDR_SCR        8'hFF
`define RSW_ADDR_WDCLR      8'hE3
`define RSW_ADDR_SLPSEL     8'hE0
`define RSW_SCR_GIE_BIT     7
`define RSW_SCR_WDRF_BIT    5
`define RSW_SCR_PORF_BIT    4
`define RSW_SCR_SLEEP_BIT   3
`define RSW_SCR_HALT_BIT    0
`define RSW_SCR_RESET       8'h10
`define RSW_WDCLR_FULL      8'h38
`define RSW_WD_LIMIT        2'h3
`define RSW_OSC_RECOVER     2'h3
`define RSW_SLPSEL_RESET    2'h0
`define RSW_CLK_HZ          25000000
`define RSW_HOLDOFF_MS      20
`define RSW_HOLDOFF_CYC     ((`RSW_CLK_HZ / 1000) * `RSW_HOLDOFF_MS)

`endif

// File: shared/rsw_pkg.sv
// types for the reset, sleep and watchdog controller
// assumes no surroundings beyond the design files
package rsw_pkg;
  // sleep sequencer states
  typedef enum logic [2:0] {
    SLP_AWAKE,
    SLP_REQ,
    SLP_WAIT_NEG,
    SLP_DOWN,
    SLP_WAKE_UP,
    SLP_SAMPLE,
    SLP_RECOVER,
    SLP_RELEASE
  } rsw_slp_t;
endpackage

// File: shared/rsw_tick_if.sv
// tick bundle between the sleep timer and the main controller
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface rsw_tick_if;
  logic       lp_rise;  // low-power clock rising edge, one cycle
  logic       lp_fall;  // low-power clock falling edge, one cycle
  logic       clr;      // clear the sleep timer count
  logic [1:0] sel;      // selected sleep period
  logic       ovf;      // sleep timer overflow, one cycle
  modport timer (input clr, input sel, input lp_rise, output ovf);
  modport ctrl  (output clr, output sel, output lp_rise, output lp_fall,
                 input ovf);
endinterface

// File: logic/rsw_sleep_timer.sv
// sleep timer counting low-power clock rising edges
// assumes edge pulses already synchronised to the system clock
`timescale 1ns/1ps
module rsw_sleep_timer #(
  parameter int unsigned CNT_W = 12  // counter width
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic CE_I,
  rsw_tick_if.timer tk
);
  logic [CNT_W-1:0] cnt_q;   // running count
  logic [CNT_W-1:0] limit;   // terminal count for the chosen period

  // period select: 64, 512, 1024 or full range of low-power ticks
  always_comb begin
    case (tk.sel)
      2'h0:    limit = CNT_W'(63);
      2'h1:    limit = CNT_W'(511);
      2'h2:    limit = CNT_W'(1023);
      default: limit = '1;
    endcase
  end

  // count ticks and wrap at the terminal count
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_q <= '0;
    end else if (CE_I) begin
      if (tk.clr) begin
        cnt_q <= '0;
      end else if (tk.lp_rise) begin
        cnt_q <= (cnt_q >= limit) ? '0 : cnt_q + 1'b1;
      end
    end
  end

  // overflow fires awake or asleep R15 R22
  assign tk.ovf = CE_I && !tk.clr && tk.lp_rise && (cnt_q >= limit);
endmodule

// File: logic/rsw_ctrl.sv
// reset, sleep and watchdog controller for the processor core
// assumes a plain register port on CLK_I and an asynchronous lp clock pin
`timescale 1ns/1ps
`include "rsw_defs.svh"

// Notes on behaviour
// R1 - sleep forces internal clock then stops oscillator
// R2 - three low-power cycles of oscillator recovery
// R3 - wake on internal clock; firmware reselects external
// R4 - power-up or watchdog reset restores all defaults
// R5 - after reset fetch zero, internal clocking
// R6 - power-up clock is internal divided by eight
// R7 - bit 7 mirrors global interrupt enable
// R8 - watchdog flag set by hardware, software clears
// R9 - power-up flag blocks watchdog resets
// R10 - power-up loads status register with 0x10
// R11 - processor held off about 20 ms
// R12 - bit 3 sleeps until interrupt or reset
// R13 - bit 0 halts until a reset
// R14 - clearing power-up flag arms watchdog permanently
// R15 - sleep timer overflows raise an interrupt
// R16 - watchdog resets on third overflow
// R17 - any clear write clears; 0x38 clears timer
// R18 - any unmasked pending interrupt wakes
// R19 - firmware keeps halt clear to resume
// R20 - oscillator restarts immediately on exit
// R21 - next instruction before service routine
// R22 - sleep interrupt fires while awake too
// R23 - halt request, ack, then power-down on fall
// R24 - wake sequence stepped on low-power edges
// R25 - cause flags clear on zero, reserved zero
module rsw_ctrl #(
  parameter int unsigned HOLDOFF_CYC = `RSW_HOLDOFF_CYC,  // start delay
  parameter int unsigned TMR_W       = 12                 // timer width
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       LP_CLK_I,
  input  wire logic       GIE_I,
  input  wire logic       IRQ_PEND_I,
  input  wire logic       BUS_HALT_ACK_I,
  input  wire logic       PROC_CLK_FALL_I,
  output logic            BUS_HALT_REQ_O,
  output logic            POWER_DOWN_O,
  output logic            OSC_RUN_O,
  output logic            FORCE_INT_CLK_O,
  output logic            PROC_HOLD_O,
  output logic            PROC_HALT_O,
  output logic            SLEEP_IRQ_O,
  output logic            MON_SAMPLE_O,
  output logic            SYS_RST_O
);
  rsw_tick_if tk ();

  logic                lp_s1_q;      // first synchroniser stage
  logic                lp_s2_q;      // second synchroniser stage
  logic                lp_s3_q;      // delayed copy for edge detect
  logic                wd_rst_q;     // watchdog reset pulse register
  logic                wd_armed_q;   // watchdog enabled latch
  logic [1:0]          wd_cnt_q;     // watchdog overflow count
  logic                wdrf_q;       // watchdog reset cause flag
  logic                porf_q;       // power-up reset cause flag
  logic                sleep_q;      // sleep request bit
  logic                halt_q;       // halt bit
  logic [1:0]          slpsel_q;     // sleep period select
  logic [1:0]          rec_q;        // oscillator recovery count
  logic [31:0]         hold_q;       // power-up hold-off count
  logic                hold_run_q;   // hold-off in progress
  logic [7:0]          rdata_q;      // read data register
  logic                irq_q;        // sleep timer interrupt pulse
  rsw_pkg::rsw_slp_t   st_q;         // sleep sequencer state
  rsw_pkg::rsw_slp_t   st_d;         // next sequencer state
  logic                wr_scr;       // write to status register
  logic                wr_clr;       // write to watchdog clear
  logic                rst_any;      // reset condition, reset input only, watchdog not included
  logic [7:0]          scr_val;      // status register read view

  assign wr_scr  = WR_I && (ADDR_I == `RSW_ADDR_SCR);
  assign wr_clr  = WR_I && (ADDR_I == `RSW_ADDR_WDCLR);
  assign rst_any = RST_I;

  // synchronise the low-power clock pin
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lp_s1_q <= 1'b0;
      lp_s2_q <= 1'b0;
      lp_s3_q <= 1'b0;
    end else if (CE_I) begin
      lp_s1_q <= LP_CLK_I;
      lp_s2_q <= lp_s1_q;
      lp_s3_q <= lp_s2_q;
    end
  end

  assign tk.lp_rise = lp_s2_q && !lp_s3_q;
  assign tk.lp_fall = !lp_s2_q && lp_s3_q;
  assign tk.sel     = slpsel_q;
  // 0x38 to the clear register also restarts the timer
  // a watchdog reset returns the timer to its default count too
  assign tk.clr     = (wr_clr && (WDATA_I == `RSW_WDCLR_FULL)) || // R17
                      wd_rst_q; // R4

  rsw_sleep_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .CLK_I (CLK_I),
    .RST_I (rst_any),
    .CE_I  (CE_I),
    .tk    (tk)
  );

  // sleep timer interrupt pulse, registered
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_q <= 1'b0;
    end else if (CE_I) begin
      irq_q <= tk.ovf; // R15 R22
    end
  end

  // power-up flag: set by reset, cleared by writing zero
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      porf_q <= 1'b1; // R10
    end else if (CE_I) begin
      if (wr_scr && !WDATA_I[`RSW_SCR_PORF_BIT]) begin
        porf_q <= 1'b0; // R25
      end
    end
  end

  // watchdog arm latch, only a power-up reset disarms it
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_armed_q <= 1'b0;
    end else if (CE_I) begin
      if (!porf_q) begin
        wd_armed_q <= 1'b1; // R14
      end
    end
  end

  // watchdog counter of timer overflows
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_cnt_q <= 2'h0;
      wd_rst_q <= 1'b0;
    end else if (CE_I) begin
      wd_rst_q <= 1'b0;
      if (wd_rst_q) begin
        wd_cnt_q <= 2'h0;
      end else if (wr_clr) begin
        wd_cnt_q <= 2'h0; // R17
      end else if (tk.ovf && wd_armed_q && !porf_q) begin
        // third overflow fires the reset R16 R9
        if (wd_cnt_q == `RSW_WD_LIMIT - 2'h1) begin
          wd_cnt_q <= 2'h0;
          wd_rst_q <= 1'b1;
        end else begin
          wd_cnt_q <= wd_cnt_q + 2'h1;
        end
      end
    end
  end

  // watchdog cause flag: set wins over a clearing write
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wdrf_q <= 1'b0;
    end else if (CE_I) begin
      if (wd_rst_q) begin
        wdrf_q <= 1'b1; // R8
      end else if (wr_scr && !WDATA_I[`RSW_SCR_WDRF_BIT]) begin
        wdrf_q <= 1'b0; // R25
      end
    end
  end

  // sleep and halt bits; a watchdog reset restores defaults
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_q  <= 1'b0;
      halt_q   <= 1'b0;
      slpsel_q <= `RSW_SLPSEL_RESET;
    end else if (CE_I) begin
      if (wd_rst_q) begin
        sleep_q  <= 1'b0; // R4
        halt_q   <= 1'b0; // R13
        slpsel_q <= `RSW_SLPSEL_RESET;
      end else begin
        if (wr_scr) begin
          halt_q <= halt_q | WDATA_I[`RSW_SCR_HALT_BIT]; // R13
        end
        if (wr_scr && WDATA_I[`RSW_SCR_SLEEP_BIT]) begin
          sleep_q <= 1'b1; // R12
        end else if (st_q == rsw_pkg::SLP_RELEASE) begin
          sleep_q <= 1'b0;
        end
        if (WR_I && ADDR_I == `RSW_ADDR_SLPSEL) begin
          slpsel_q <= WDATA_I[1:0];
        end
      end
    end
  end

  // hold-off after power-up reset release
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_q     <= 32'h0;
      hold_run_q <= 1'b1;
    end else if (CE_I) begin
      if (hold_run_q) begin
        if (hold_q >= HOLDOFF_CYC - 1) begin
          hold_run_q <= 1'b0; // R11
        end else begin
          hold_q <= hold_q + 32'h1;
        end
      end
    end
  end

  // sleep sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      rsw_pkg::SLP_AWAKE: begin
        if (sleep_q && !halt_q) begin
          st_d = rsw_pkg::SLP_REQ; // R23
        end
      end
      rsw_pkg::SLP_REQ: begin
        if (BUS_HALT_ACK_I) begin
          st_d = rsw_pkg::SLP_WAIT_NEG; // R23
        end
      end
      rsw_pkg::SLP_WAIT_NEG: begin
        if (PROC_CLK_FALL_I) begin
          st_d = rsw_pkg::SLP_DOWN; // R23 R1
        end
      end
      rsw_pkg::SLP_DOWN: begin
        // any unmasked interrupt, gie ignored R18
        if (IRQ_PEND_I && tk.lp_fall && !halt_q) begin
          st_d = rsw_pkg::SLP_WAKE_UP; // R24 R19
        end
      end
      rsw_pkg::SLP_WAKE_UP: begin
        if (tk.lp_rise) begin
          st_d = rsw_pkg::SLP_SAMPLE; // R24 R20
        end
      end
      rsw_pkg::SLP_SAMPLE: begin
        if (tk.lp_rise) begin
          st_d = rsw_pkg::SLP_RECOVER; // R24
        end
      end
      rsw_pkg::SLP_RECOVER: begin
        if (tk.lp_fall && rec_q == `RSW_OSC_RECOVER) begin
          st_d = rsw_pkg::SLP_RELEASE; // R2 R24
        end
      end
      rsw_pkg::SLP_RELEASE: begin
        st_d = rsw_pkg::SLP_AWAKE; // R21
      end
      default: begin
        st_d = rsw_pkg::SLP_AWAKE;
      end
    endcase
  end

  // sequencer state, watchdog reset returns to awake
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= rsw_pkg::SLP_AWAKE;
    end else if (CE_I) begin
      st_q <= wd_rst_q ? rsw_pkg::SLP_AWAKE : st_d; // R4
    end
  end

  // oscillator recovery counts low-power rising edges after restart
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rec_q <= 2'h0;
    end else if (CE_I) begin
      // count starts only once the oscillator is powered again
      if (st_q == rsw_pkg::SLP_DOWN || st_q == rsw_pkg::SLP_WAKE_UP) begin
        rec_q <= 2'h0;
      end else if (tk.lp_rise && rec_q != `RSW_OSC_RECOVER) begin
        rec_q <= rec_q + 2'h1; // R2
      end
    end
  end

  // status register read view, reserved bits zero
  always_comb begin
    scr_val = 8'h00; // R25
    scr_val[`RSW_SCR_GIE_BIT]   = GIE_I; // R7
    scr_val[`RSW_SCR_WDRF_BIT]  = wdrf_q;
    scr_val[`RSW_SCR_PORF_BIT]  = porf_q;
    scr_val[`RSW_SCR_SLEEP_BIT] = sleep_q;
    scr_val[`RSW_SCR_HALT_BIT]  = halt_q;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else if (CE_I) begin
      if (RD_I && ADDR_I == `RSW_ADDR_SCR) begin
        rdata_q <= scr_val;
      end else if (RD_I && ADDR_I == `RSW_ADDR_SLPSEL) begin
        rdata_q <= {6'h00, slpsel_q};
      end else begin
        rdata_q <= 8'h00; // clear register is write-only
      end
    end
  end

  assign RDATA_O        = rdata_q;
  assign SLEEP_IRQ_O    = irq_q;
  // request raised at once from the sleep bit R23
  assign BUS_HALT_REQ_O = (st_q != rsw_pkg::SLP_AWAKE) ||
                          (sleep_q && !halt_q);
  // power-down stands until the lp rise after the wake edge
  assign POWER_DOWN_O   = (st_q == rsw_pkg::SLP_DOWN) ||
                          (st_q == rsw_pkg::SLP_WAKE_UP); // R23 R24
  // oscillator off only while powered down R1 R20
  assign OSC_RUN_O      = !POWER_DOWN_O;
  // internal clock forced through sleep and wake R1 R3 R5 R6
  assign FORCE_INT_CLK_O = (st_q != rsw_pkg::SLP_AWAKE);
  assign MON_SAMPLE_O   = (st_q == rsw_pkg::SLP_SAMPLE) && tk.lp_rise;
  assign PROC_HOLD_O    = hold_run_q; // R11 R5
  assign PROC_HALT_O    = halt_q; // R13
  assign SYS_RST_O      = wd_rst_q; // R4
endmodule

// File: tb/rsw_monitor.sv
// concurrent checks on the controller's top ports
// assumes binding onto rsw_ctrl in a single clock domain
`timescale 1ns/1ps
module rsw_monitor (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       GIE_I,
  input wire logic       PROC_CLK_FALL_I,
  input wire logic       BUS_HALT_REQ_O,
  input wire logic       POWER_DOWN_O,
  input wire logic       OSC_RUN_O,
  input wire logic       FORCE_INT_CLK_O,
  input wire logic       PROC_HALT_O,
  input wire logic       MON_SAMPLE_O,
  input wire logic       SYS_RST_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sleep_req_a: assert property (WR_I && CE_I && ADDR_I == 8'hFF &&
    WDATA_I[3] && !PROC_HALT_O |=> BUS_HALT_REQ_O)
    else $error("sleep write raised no halt request");
  status_read_a: assert property (RD_I && CE_I && ADDR_I == 8'hFF
    |=> RDATA_O[7] == $past(GIE_I) && RDATA_O[6] == 1'h0
    && RDATA_O[2:1] == 2'h0) else $error("status mirror or reserved bad");
  clr_read_a: assert property (RD_I && CE_I && ADDR_I == 8'hE3
    |=> RDATA_O == 8'h00) else $error("clear register read not zero");
  pd_entry_a: assert property ($rose(POWER_DOWN_O)
    |-> BUS_HALT_REQ_O && $past(PROC_CLK_FALL_I))
    else $error("power-down not after processor falling edge");
  pd_clock_a: assert property (POWER_DOWN_O
    |-> FORCE_INT_CLK_O && !OSC_RUN_O)
    else $error("clock not forced or oscillator running");
  pd_req_a: assert property (POWER_DOWN_O |-> BUS_HALT_REQ_O)
    else $error("halt request dropped while powered down");
  wd_default_a: assert property (SYS_RST_O
    |-> ##[1:2] !PROC_HALT_O && !BUS_HALT_REQ_O)
    else $error("watchdog reset left state");
  halt_hold_a: assert property (PROC_HALT_O && !SYS_RST_O
    && !$past(SYS_RST_O) |=> PROC_HALT_O)
    else $error("halt released without reset");
  sample_a: assert property (MON_SAMPLE_O
    |-> !POWER_DOWN_O && BUS_HALT_REQ_O)
    else $error("monitor sample out of wake order");

  cover property ($rose(POWER_DOWN_O));
  cover property (MON_SAMPLE_O);
  cover property (SYS_RST_O);
endmodule

bind rsw_ctrl rsw_monitor u_rsw_monitor (.CLK_I, .RST_I, .CE_I, .ADDR_I,
  .WDATA_I, .WR_I, .RD_I, .RDATA_O, .GIE_I, .PROC_CLK_FALL_I,
  .BUS_HALT_REQ_O, .POWER_DOWN_O, .OSC_RUN_O, .FORCE_INT_CLK_O,
  .PROC_HALT_O, .MON_SAMPLE_O, .SYS_RST_O);

// File: tb/rsw_core_model.sv
// processor core stand-in answering the sleep handshake
// assumes the controller's clock; processor clock is a divided copy
`timescale 1ns/1ps
module rsw_core_model #(
  parameter int unsigned DIV = 4  // system cycles per processor clock
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic halt_req_i,
  output logic      halt_ack_o,
  output logic      clk_fall_o
);
  int unsigned phase_q;  // place within the processor clock period

  // processor clock phase, larger DIV answers more slowly
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 0;
    end else begin
      phase_q <= (phase_q == DIV - 1) ? 0 : phase_q + 1;
    end
  end

  // acknowledge follows the request at the processor rising edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      halt_ack_o <= 1'b0;
    end else if (phase_q == 0) begin
      halt_ack_o <= halt_req_i;
    end
  end

  // one-cycle pulse standing for the processor falling edge
  assign clk_fall_o = (phase_q == DIV / 2);
endmodule

// File: tb/testbench.sv
// self-checking bench for the reset, sleep and watchdog controller
// assumes the core stand-in and the bound monitor
`timescale 1ns/1ps
module testbench;
  localparam int unsigned HOLD = 20;  // shortened start delay
  logic       clk, rst, ce, lp, global_irq_enable, irq, ack, fall, wr, rd;
  logic [7:0] addr, wdata, rdata;
  logic       req, pd, osc, frc, hold, halt, sirq, mon, srst;
  int         fail_count = 0;
  int         check_count = 0;
  int         rst_seen = 0;  // watchdog reset pulses seen
  int         mon_seen = 0;  // supply monitor sample pulses seen
  int         n;

  rsw_ctrl #(.HOLDOFF_CYC(HOLD), .TMR_W(12)) u_rsw_ctrl (
    .CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .LP_CLK_I(lp), .GIE_I(global_irq_enable), .IRQ_PEND_I(irq),
    .BUS_HALT_ACK_I(ack), .PROC_CLK_FALL_I(fall),
    .BUS_HALT_REQ_O(req), .POWER_DOWN_O(pd), .OSC_RUN_O(osc),
    .FORCE_INT_CLK_O(frc), .PROC_HOLD_O(hold), .PROC_HALT_O(halt),
    .SLEEP_IRQ_O(sirq), .MON_SAMPLE_O(mon), .SYS_RST_O(srst));
  rsw_core_model #(.DIV(4)) u_rsw_core_model (.clk_i(clk), .rst_i(rst),
    .halt_req_i(req), .halt_ack_o(ack), .clk_fall_o(fall));

  // system clock and a slower stand-in low-power clock, free running
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lp = 1'b0;
    #7;
    forever #200 lp = ~lp;
  end
  always @(posedge clk) begin
    if (srst === 1'b1) rst_seen++;
    if (mon === 1'b1) mon_seen++;
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data judged in the following cycle
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // start delay, reset values, mirror, refused writes
  task automatic t_reset;
    check(8'(hold), 8'h01);
    repeat (HOLD - 1) @(posedge clk) #1;
    check(8'(hold), 8'h01);
    repeat (1) @(posedge clk) #1;
    check(8'(hold), 8'h00);
    check(8'(osc), 8'h01);
    rd_reg(8'hFF, 8'h10);
    @(posedge clk) global_irq_enable <= 1'b1;
    rd_reg(8'hFF, 8'h90);
    @(posedge clk) global_irq_enable <= 1'b0;
    rd_reg(8'hE3, 8'h00);
    rd_reg(8'h55, 8'h00);
    wr_reg(8'hFF, 8'h36);
    rd_reg(8'hFF, 8'h10);
    // a sleep write while the clock enable is low must not land
    @(posedge clk) ce <= 1'b0;
    wr_reg(8'hFF, 8'h08);
    check(8'(req), 8'h00);
    @(posedge clk) ce <= 1'b1;
    rd_reg(8'hFF, 8'h10);
  endtask
  // sleep entry, stay asleep, wake on a pending interrupt
  task automatic t_sleep;
    wr_reg(8'hFF, 8'h18);
    check(8'(req), 8'h01);
    for (n = 0; n < 40 && pd !== 1'b1; n++) @(posedge clk) #1;
    check(8'(pd), 8'h01);
    check(8'(frc), 8'h01);
    check(8'(osc), 8'h00);
    repeat (60) @(posedge clk) #1;
    check(8'(pd), 8'h01);
    @(posedge clk) irq <= 1'b1;
    for (n = 0; n < 60 && pd !== 1'b0; n++) @(posedge clk) #1;
    check(8'(pd), 8'h00);
    check(8'(osc), 8'h01);
    for (n = 0; n < 200 && req !== 1'b0; n++) @(posedge clk) #1;
    check(8'(req), 8'h00);
    check(8'(frc), 8'h00);
    check(8'(mon_seen), 8'h01);
    // three lp periods of ten system clocks after power-down ends
    check(8'(n >= 30), 8'h01);
    @(posedge clk) irq <= 1'b0;
    rd_reg(8'hFF, 8'h10);
  endtask
  // arm the watchdog, feed it, and clear the timer with the full code
  task automatic t_watchdog;
    wr_reg(8'hFF, 8'h00);
    rd_reg(8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (n = 0; n < 1500 && sirq !== 1'b1; n++) @(posedge clk) #1;
      check(8'(sirq), 8'h01);
      wr_reg(8'hE3, 8'(i));
    end
    // clear mid-period: the next overflow then needs a full 64 ticks
    repeat (320) @(posedge clk) #1;
    wr_reg(8'hE3, 8'h38);
    for (n = 0; n < 1500 && sirq !== 1'b1; n++) @(posedge clk) #1;
    check(8'(n > 600), 8'h01);
    check(8'(rst_seen), 8'h00);
  endtask
  // halt until the watchdog resets, then cause flag handling
  task automatic t_halt;
    wr_reg(8'hE3, 8'h00);
    wr_reg(8'hFF, 8'h01);
    check(8'(halt), 8'h01);
    for (n = 0; n < 4500 && rst_seen == 0; n++) @(posedge clk) #1;
    check(8'(rst_seen), 8'h01);
    // third overflow lands two to three periods of 640 after the clear
    check(8'(n > 1280 && n < 1930), 8'h01);
    repeat (3) @(posedge clk) #1;
    check(8'(halt), 8'h00);
    rd_reg(8'hFF, 8'h20);
    wr_reg(8'hFF, 8'h00);
    rd_reg(8'hFF, 8'h00);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    global_irq_enable = 1'b0;
    irq = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_sleep();
    t_watchdog();
    t_halt();
    summarize();
  end
  // hang guard
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
endmodule
